// ==== core/cgu_fout.sv ====
/*
 * cgu_fout: one divided clock output channel.
 * Assumes oscillator levels arrive sampled, synchronous to clk_i.
 */
`timescale 1ns/100ps
module cgu_fout
  import cgu_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // oscillators, {ext, low, int}
  input wire logic [2:0] osc_lvl_i,
  input wire logic [2:0] osc_rdy_i,
  // channel control
  input wire cgu_out_ctl_t ctl_i,
  // pin
  output logic clk_o
);

  typedef struct packed {
    logic prev;
    logic [CNT_W-1:0] cnt;
    logic out;
  } cgu_fout_st_t;

  cgu_fout_st_t q, d;
  logic cur;
  logic rise;
  logic divided;

  always_comb begin
    d = q;
    cur = cgu_pick(osc_lvl_i, ctl_i.src); // [R7]
    rise = cur & ~q.prev;
    d.prev = cur;
    // free-running, cleared only by reset: enable does not resync it
    if (rise) begin
      d.cnt = q.cnt + 1'b1; // [R20]
    end
    if (ctl_i.div == 3'h0) begin
      divided = cur;
    end else begin
      divided = q.cnt[ctl_i.div - 3'h1]; // [R8]
    end
    // enable gates level directly, so edges may be cut short [R10]
    d.out = ctl_i.en & cgu_pick(osc_rdy_i, ctl_i.src) & divided; // [R9] [R11] [R20]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clk_o = q.out;

  a_out_disabled: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
    !ctl_i.en |=> !clk_o)
    else $error("clock output active while channel disabled");

  a_out_waits_rdy: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
    !cgu_pick(osc_rdy_i, ctl_i.src) |=> !clk_o)
    else $error("clock output before oscillator ready");

  a_cnt_step: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R20]
    rise |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("divider counter missed a source edge");

endmodule : cgu_fout

// ==== core/cgu_pkg.sv ====
/*
 * cgu_pkg: register map, field layouts, reset values and carrier types of the
 * clock generator unit. Assumes 32-bit AXI4-Lite data and 8-bit registers.
 */
package cgu_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SRC = 16'h5060;
  localparam logic [15:0] IDX_CTL = 16'h5061;
  localparam logic [15:0] IDX_OUT_A = 16'h5064;
  localparam logic [15:0] IDX_OUT_B = 16'h5065;
  localparam logic [15:0] IDX_WAIT = 16'h507D;
  localparam logic [15:0] IDX_PCLK = 16'h5080;
  localparam logic [15:0] IDX_CORE_CLOCK = 16'h5081;

  // reset values
  localparam logic [7:0] RST_SRC = 8'h10;
  localparam logic [7:0] RST_CTL = 8'h04;
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_WAIT = 8'h00;
  localparam logic [7:0] RST_PCLK = 8'h03;
  localparam logic [7:0] RST_CORE_CLOCK = 8'h00;

  // read masks: reserved positions read zero
  localparam logic [7:0] MASK_SRC = 8'hD3;
  localparam logic [7:0] MASK_CTL = 8'h07;
  localparam logic [7:0] MASK_OUT = 8'h7D;
  localparam logic [7:0] MASK_PCLK = 8'h03;

  // source codes, shared by system clock and output channels
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_LOW = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_RSV = 2'h3;
  localparam logic [1:0] GATE_ON = 2'h3;
  localparam logic [1:0] GATE_OFF = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] int_freq;
    logic rsv5;
    logic low_sel;
    logic [1:0] rsv3_2;
    logic [1:0] sys_src;
  } cgu_src_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic int_en;
    logic low_en;
    logic ext_en;
  } cgu_ctl_t;

  typedef struct packed {
    logic rsv7;
    logic [2:0] div;
    logic [1:0] src;
    logic rsv1;
    logic en;
  } cgu_out_ctl_t;

  typedef struct packed {
    cgu_src_t src;
    cgu_ctl_t ctl;
    cgu_out_ctl_t out_a;
    cgu_out_ctl_t out_b;
    logic [7:0] wait_ctl;
    logic [7:0] pclk;
    logic [7:0] core_clock;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] widx;
    logic [7:0] wdata;
    logic wlane;
    logic pclk_out;
  } cgu_top_st_t;

  // picks an oscillator bit by source code; vec is {ext, low, int}
  function automatic logic cgu_pick(input logic [2:0] vec, input logic [1:0] code);
    case (code)
      SRC_INT: cgu_pick = vec[0];
      SRC_LOW: cgu_pick = vec[1];
      SRC_EXT: cgu_pick = vec[2];
      default: cgu_pick = 1'b0;
    endcase
  endfunction : cgu_pick

endpackage : cgu_pkg

// ==== core/cgu_top.sv ====
/*
 * cgu_top: clock generator unit register file, peripheral clock gate and two
 * divided clock outputs, reached over AXI4-Lite.
 * Assumes oscillator levels and ready flags are synchronous to MCLK_I.
 */
// Function
// R1: peripheral clock is the system clock, unmodified, only gated.
// R2: gate field 0x3 runs peripheral clock, 0x0 stops it; resets to 0x3.
// R3: software never writes 0x2 or 0x1 to the gate field.
// R4: software keeps peripheral clock on while its modules must run.
// R5: software keeps low-speed oscillator on for timers and watchdog.
// R6: two identical output channels, each with source, divider and enable.
// R7: channel source: 0 internal, 1 low-speed, 2 external; resets 0.
// R8: channel divider divides by two to the field value; resets 0.
// R9: enable bit drives divided clock onto pin; clear stops; resets 0.
// R10: enable is not synchronised, first or last pulse may be cut.
// R11: output starts only after selected oscillator is stable.
// R12: software selects clock output pin function in the port block.
// R13: registers at indices 5060, 5061, 5064, 5065, 507D, 5080, 5081.
// R14: software writes reserved bits zero; reserved source bits read zero.
// R15: source bits 7:6 set internal oscillator frequency; resets 0.
// R16: source bits 1:0 select system clock; 3 reserved; resets 0.
// R17: source bit 4 selects low-speed source; 1 second, resets 1.
// R18: system source write ignored if named oscillator is not enabled.
// R19: oscillator selected as system clock cannot be disabled.
// R20: channel divider is free-running counter; pin low while disabled.
// R21: registers 8 bits, written synchronously, default on reset.
`timescale 1ns/100ps
module cgu_top
  import cgu_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // oscillators, {ext, low, int}
  input wire logic [2:0] OSC_LVL_I,
  input wire logic [2:0] OSC_RDY_I,
  // oscillator and clock tree control
  output logic [2:0] OSC_EN_O,
  output logic [1:0] SYS_SRC_O,
  output logic [1:0] INT_FREQ_O,
  output logic LOW_SRC_O,
  output logic [7:0] WAIT_CTL_O,
  output logic [7:0] CORE_GEAR_O,
  // clocks out
  output logic PCLK_O,
  output logic CLK_OUT_A_O,
  output logic CLK_OUT_B_O
);

  function automatic logic [15:0] reg_idx(input logic [ADDR_W-1:0] addr);
    reg_idx = 16'(addr[ADDR_W-1:2]);
  endfunction : reg_idx

  // enables rearranged into {ext, low, int} order
  function automatic logic [2:0] en_vec(input cgu_ctl_t c);
    en_vec = {c.ext_en, c.low_en, c.int_en};
  endfunction : en_vec

  cgu_top_st_t q, d;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic commit;
  logic wr_src;
  logic sys_lvl;
  logic [2:0] keep_en;
  logic [7:0] rval;
  logic rhit;
  logic [15:0] ridx;

  assign aw_hs = S_AXI_AWVALID_I & q.awrdy;
  assign w_hs = S_AXI_WVALID_I & q.wrdy;
  assign ar_hs = S_AXI_ARVALID_I & q.arrdy;
  // both halves held and no response pending: apply the write now
  assign commit = ~q.awrdy & ~q.wrdy & ~q.bvalid;
  assign wr_src = commit & q.wlane & (q.widx == IDX_SRC);
  assign sys_lvl = cgu_pick(OSC_LVL_I, q.src.sys_src);

  always_comb begin
    d = q;
    ridx = reg_idx(S_AXI_ARADDR_I);
    keep_en = 3'h0;
    rval = 8'h00;
    rhit = 1'b1;

    // write channel capture, either order
    if (aw_hs) begin
      d.awrdy = 1'b0;
      d.widx = reg_idx(S_AXI_AWADDR_I);
    end
    if (w_hs) begin
      d.wrdy = 1'b0;
      d.wdata = S_AXI_WDATA_I[7:0];
      d.wlane = S_AXI_WSTRB_I[0];
    end

    if (commit) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      // a write without lane 0 strobe is answered but changes nothing
      case (q.widx)
        IDX_SRC: begin
          if (q.wlane) begin
            d.src.int_freq = q.wdata[7:6]; // [R15]
            d.src.low_sel = q.wdata[4]; // [R17]
            // refused unless the target oscillator is enabled
            if (cgu_pick(en_vec(q.ctl), q.wdata[1:0])) begin
              d.src.sys_src = q.wdata[1:0]; // [R16] [R18]
            end
          end
        end
        IDX_CTL: begin
          case (q.src.sys_src)
            SRC_INT: keep_en = 3'h4;
            SRC_LOW: keep_en = 3'h2;
            SRC_EXT: keep_en = 3'h1;
            default: keep_en = 3'h0;
          endcase
          if (q.wlane) begin
            d.ctl = cgu_ctl_t'(q.wdata & MASK_CTL);
            d.ctl[2:0] = q.wdata[2:0] | keep_en; // [R19]
          end
        end
        IDX_OUT_A: begin
          if (q.wlane) begin
            d.out_a = cgu_out_ctl_t'(q.wdata & MASK_OUT); // [R6] [R21]
          end
        end
        IDX_OUT_B: begin
          if (q.wlane) begin
            d.out_b = cgu_out_ctl_t'(q.wdata & MASK_OUT); // [R6] [R21]
          end
        end
        IDX_WAIT: begin
          if (q.wlane) begin
            d.wait_ctl = q.wdata;
          end
        end
        IDX_PCLK: begin
          if (q.wlane) begin
            d.pclk = q.wdata & MASK_PCLK; // [R2]
          end
        end
        IDX_CORE_CLOCK: begin
          if (q.wlane) begin
            d.core_clock = q.wdata;
          end
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid & S_AXI_BREADY_I) begin
      d.bvalid = 1'b0;
      d.awrdy = 1'b1;
      d.wrdy = 1'b1;
    end

    // read decode [R13]
    case (ridx)
      IDX_SRC: rval = q.src & MASK_SRC; // [R14]
      IDX_CTL: rval = q.ctl & MASK_CTL;
      IDX_OUT_A: rval = q.out_a & MASK_OUT;
      IDX_OUT_B: rval = q.out_b & MASK_OUT;
      IDX_WAIT: rval = q.wait_ctl;
      IDX_PCLK: rval = q.pclk & MASK_PCLK;
      IDX_CORE_CLOCK: rval = q.core_clock;
      default: rhit = 1'b0;
    endcase
    if (ar_hs) begin
      d.arrdy = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = {24'h000000, rval};
      d.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid & S_AXI_RREADY_I) begin
      d.rvalid = 1'b0;
      d.arrdy = 1'b1;
    end

    // undivided system clock; codes 1 and 2 also stop it
    d.pclk_out = sys_lvl & (q.pclk[1:0] == GATE_ON); // [R1] [R2]
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.src <= cgu_src_t'(RST_SRC); // [R21]
      q.ctl <= cgu_ctl_t'(RST_CTL);
      q.out_a <= cgu_out_ctl_t'(RST_OUT);
      q.out_b <= cgu_out_ctl_t'(RST_OUT);
      q.wait_ctl <= RST_WAIT;
      q.pclk <= RST_PCLK;
      q.core_clock <= RST_CORE_CLOCK;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.arrdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // output channels [R6]
  cgu_fout u_out_a (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .osc_lvl_i(OSC_LVL_I),
    .osc_rdy_i(OSC_RDY_I),
    .ctl_i(q.out_a),
    .clk_o(CLK_OUT_A_O)
  );

  cgu_fout u_out_b (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .osc_lvl_i(OSC_LVL_I),
    .osc_rdy_i(OSC_RDY_I),
    .ctl_i(q.out_b),
    .clk_o(CLK_OUT_B_O)
  );

  assign S_AXI_AWREADY_O = q.awrdy;
  assign S_AXI_WREADY_O = q.wrdy;
  assign S_AXI_BVALID_O = q.bvalid;
  assign S_AXI_BRESP_O = q.bresp;
  assign S_AXI_ARREADY_O = q.arrdy;
  assign S_AXI_RVALID_O = q.rvalid;
  assign S_AXI_RDATA_O = q.rdata;
  assign S_AXI_RRESP_O = q.rresp;
  assign OSC_EN_O = q.ctl[2:0];
  assign SYS_SRC_O = q.src.sys_src;
  assign INT_FREQ_O = q.src.int_freq;
  assign LOW_SRC_O = q.src.low_sel;
  assign WAIT_CTL_O = q.wait_ctl;
  assign CORE_GEAR_O = q.core_clock;
  assign PCLK_O = q.pclk_out;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_pclk_stopped: assert property ( // [R2]
    (q.pclk[1:0] == GATE_OFF) |=> !PCLK_O)
    else $error("peripheral clock runs while gate is off");

  a_pclk_follows: assert property ( // [R1]
    (q.pclk[1:0] == GATE_ON) |=> PCLK_O == $past(sys_lvl))
    else $error("peripheral clock differs from system clock");

  a_src_refused: assert property ( // [R18]
    wr_src && !cgu_pick(en_vec(q.ctl), q.wdata[1:0])
      |=> q.src.sys_src == $past(q.src.sys_src))
    else $error("system source changed to a stopped oscillator");

  a_src_taken: assert property ( // [R16]
    wr_src && cgu_pick(en_vec(q.ctl), q.wdata[1:0])
      |=> q.src.sys_src == $past(q.wdata[1:0]))
    else $error("valid system source write was lost");

  a_sys_osc_on: assert property ( // [R19]
    cgu_pick(en_vec(q.ctl), q.src.sys_src))
    else $error("system clock oscillator is disabled");

  a_src_rsv_zero: assert property ( // [R14]
    ar_hs && ridx == IDX_SRC |=> S_AXI_RDATA_O[5] == 1'b0 && S_AXI_RDATA_O[3:2] == 2'h0)
    else $error("reserved source bits read nonzero");

  a_write_resp: assert property ( // [R21]
    commit |=> S_AXI_BVALID_O)
    else $error("write response missing");

  a_write_release: assert property ( // [R21]
    S_AXI_BVALID_O && S_AXI_BREADY_I |=> S_AXI_AWREADY_O && S_AXI_WREADY_O && !S_AXI_BVALID_O)
    else $error("write channels not released after response");

  a_unmapped_err: assert property ( // [R13]
    ar_hs && !rhit |=> S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR)
    else $error("unmapped read not answered with error");

  a_out_a_write: assert property ( // [R9]
    commit && q.wlane && q.widx == IDX_OUT_A |=> q.out_a.en == $past(q.wdata[0]))
    else $error("channel enable write not stored");

endmodule : cgu_top

// ==== testbench/cgu_osc_model.sv ====
/* cgu_osc_model: three oscillators and their stable flags, far side of cgu_top.
   Assumes enables arrive as {int, low, ext}; levels and flags go out as {ext, low, int}. */
`timescale 1ns/100ps
module cgu_osc_model #(
  parameter int STAB_CYC = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // oscillator side
  input wire logic [2:0] en_i,
  output logic [2:0] lvl_o,
  output logic [2:0] rdy_o
);
  logic [2:0] cnt_q;
  logic [2:0] on;
  int wait_q [3];
  assign on = {en_i[0], en_i[1], en_i[2]};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 3'h0;
      lvl_o <= 3'h0;
      rdy_o <= 3'h0;
      for (int k = 0; k < 3; k++) wait_q[k] <= 0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      // stopped oscillator sits low: int period 2, ext 4, low 8
      lvl_o <= {cnt_q[1], cnt_q[2], cnt_q[0]} & on;
      for (int k = 0; k < 3; k++) begin
        // stable only after a fixed wait from enable
        wait_q[k] <= on[k] ? ((wait_q[k] < STAB_CYC) ? wait_q[k] + 1 : wait_q[k]) : 0;
        rdy_o[k] <= on[k] && (wait_q[k] >= STAB_CYC);
      end
    end
  end
endmodule : cgu_osc_model

// ==== testbench/cgu_top_tb.sv ====
/* cgu_top_tb: registers, peripheral gate and clock outputs of cgu_top over AXI4-Lite.
   Assumes cgu_osc_model as oscillator source. */
`timescale 1ns/100ps
module cgu_top_tb;
  import cgu_pkg::*;
  logic mclk, rst_n, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic low_src, pclk, out_a, out_b;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, sys_src, int_freq;
  logic [2:0] lvl, rdy, osc_en;
  logic [7:0] wait_ctl, gear;
  int n_errors = 0;
  int n_compared = 0;

  cgu_top uut (.MCLK_I(mclk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .OSC_LVL_I(lvl), .OSC_RDY_I(rdy), .OSC_EN_O(osc_en),
    .SYS_SRC_O(sys_src), .INT_FREQ_O(int_freq), .LOW_SRC_O(low_src),
    .WAIT_CTL_O(wait_ctl), .CORE_GEAR_O(gear), .PCLK_O(pclk), .CLK_OUT_A_O(out_a),
    .CLK_OUT_B_O(out_b));
  cgu_osc_model osc (.clk_i(mclk), .rst_n_i(rst_n), .en_i(osc_en), .lvl_o(lvl), .rdy_o(rdy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // both channels offered together; each released at its own ready
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (bvalid !== 1'b1 && t < 100);
    chk(32'({bvalid, bresp}), 32'({1'b1, er}));
    bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (arrdy === 1'b1) arv <= 1'b0;
    end while (rvalid !== 1'b1 && t < 100);
    chk(32'({rvalid, rresp}), 32'({1'b1, er}));
    chk(rdata, {24'h0, d});
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd

  // gated clock is the chosen oscillator one cycle late
  task automatic pscan(input int s, input logic on);
    logic pv;
    @(posedge mclk);
    #1 pv = lvl[s];
    repeat (12) begin
      @(posedge mclk);
      #1 chk(32'(pclk), 32'(pv & on));
      pv = lvl[s];
    end
  endtask : pscan

  // gap between the second and third rising edge of a pin
  task automatic meas(input logic ch, input int per);
    int n, t;
    logic pv, cv;
    n = 0;
    t = 0;
    pv = 1'b1;
    while (n < 3 && t < 3000) begin
      @(posedge mclk);
      #1 cv = ch ? out_b : out_a;
      t++;
      if (cv === 1'b1 && pv === 1'b0) begin
        if (n == 2) chk(t, per);
        n++;
        t = 0;
      end
      pv = cv;
    end
    if (n < 3) chk(n, 3);
  endtask : meas

  task automatic quiet(input logic ch);
    logic seen;
    seen = 1'b0;
    repeat (24) begin
      @(posedge mclk);
      #1 seen = seen | (ch ? out_b : out_a) | (ch ? out_b : out_a) === 1'bx;
    end
    chk(32'(seen), 32'h0);
  endtask : quiet

  task automatic chan(input logic ch, input logic [1:0] s, input logic [2:0] d, input int per);
    wr(ch ? IDX_OUT_B : IDX_OUT_A, {1'b0, d, s, 2'b01}, RESP_OKAY);
    rd(ch ? IDX_OUT_B : IDX_OUT_A, {1'b0, d, s, 2'b01}, RESP_OKAY);
    meas(ch, per);
  endtask : chan

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    report_and_stop;
  end

  initial begin
    logic [15:0] ri [7] = '{IDX_SRC, IDX_CTL, IDX_OUT_A, IDX_OUT_B, IDX_WAIT, IDX_PCLK, IDX_CORE_CLOCK};
    logic [7:0] rv [7] = '{8'h10, 8'h04, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    {rst_n, awv, wv, bready, arv, rready} = 6'h0;
    awaddr = 18'h0;
    araddr = 18'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int k = 0; k < 7; k++) rd(ri[k], rv[k], RESP_OKAY);
    chk({osc_en, sys_src, int_freq, low_src}, 32'h81);
    rd(16'h5062, 8'h00, RESP_SLVERR);
    wr(16'h5062, 8'hFF, RESP_SLVERR);
    wr(IDX_WAIT, 8'hA5, RESP_OKAY);
    wr(IDX_CORE_CLOCK, 8'h5A, RESP_OKAY);
    chk({wait_ctl, gear}, 32'hA55A);
    wstrb <= 4'h0;
    wr(IDX_CORE_CLOCK, 8'h00, RESP_OKAY);
    wstrb <= 4'hF;
    rd(IDX_CORE_CLOCK, 8'h5A, RESP_OKAY);
    wr(IDX_SRC, 8'h03, RESP_OKAY);
    rd(IDX_SRC, 8'h00, RESP_OKAY);
    chk(32'(low_src), 32'h0);
    for (int f = 0; f < 3; f++) begin
      wr(IDX_SRC, {f[1:0], 6'h10}, RESP_OKAY);
      chk({int_freq, low_src}, {f[1:0], 1'b1});
    end
    wr(IDX_SRC, 8'h12, RESP_OKAY);
    rd(IDX_SRC, 8'h10, RESP_OKAY);
    pscan(0, 1'b1);
    wr(IDX_PCLK, 8'h00, RESP_OKAY);
    pscan(0, 1'b0);
    wr(IDX_PCLK, 8'h03, RESP_OKAY);
    wr(IDX_CTL, 8'h05, RESP_OKAY);
    wr(IDX_SRC, 8'h12, RESP_OKAY);
    rd(IDX_SRC, 8'h12, RESP_OKAY);
    chk(32'(sys_src), 32'h2);
    wr(IDX_CTL, 8'h00, RESP_OKAY);
    rd(IDX_CTL, 8'h01, RESP_OKAY);
    wr(IDX_SRC, 8'h11, RESP_OKAY);
    rd(IDX_SRC, 8'h12, RESP_OKAY);
    pscan(2, 1'b1);
    wr(IDX_CTL, 8'h05, RESP_OKAY);
    wr(IDX_SRC, 8'h10, RESP_OKAY);
    wr(IDX_CTL, 8'h06, RESP_OKAY);
    rd(IDX_CTL, 8'h06, RESP_OKAY);
    // pins taken as already switched to clock output function outside this block
    for (int d = 0; d < 8; d++) chan(1'b0, SRC_INT, d[2:0], 2 << d);
    for (int d = 0; d < 3; d++) chan(1'b1, SRC_LOW, d[2:0], 8 << d);
    wr(IDX_OUT_A, 8'h00, RESP_OKAY);
    quiet(1'b0);
    wr(IDX_OUT_B, 8'h19, RESP_OKAY);
    quiet(1'b1);
    wr(IDX_CTL, 8'h07, RESP_OKAY);
    chk(32'(out_b), 32'h0);
    meas(1'b1, 8);
    report_and_stop;
  end
endmodule : cgu_top_tb
